// ==== hdl/power_handshake_defines.svh ====
/*
 * Timing counts and strap encodings for the module/carrier power handshake.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef POWER_HANDSHAKE_DEFINES_SVH
`define POWER_HANDSHAKE_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define DEBOUNCE_TIME_NS 1000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_TIME_NS) / (`CLK_PERIOD_NS))
`define RESET_HOLD_TIME_NS 20000
`define RESET_HOLD_CYCLES ((`RESET_HOLD_TIME_NS) / (`CLK_PERIOD_NS))
`define BOOT_FROM_NOR 1'h0
`define BOOT_FROM_CARD 1'h1

`endif

// ==== hdl/power_handshake_pkg.sv ====
/*
 * Types shared by the power handshake sequencer.
 * Assumes the defines header is compiled alongside.
 */
package power_handshake_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SUPPLY_UP,
        ST_CARRIER_UP,
        ST_WAIT_RESET,
        ST_BOOT,
        ST_STANDBY
    } seq_state_e;
endpackage

// ==== hdl/input_debouncer.sv ====
/*
 * Two-flop synchroniser followed by a stability filter.
 * Assumes the input is asynchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`include "power_handshake_defines.svh"
module input_debouncer #(
    parameter int STABLE_CYCLES = `DEBOUNCE_CYCLES,
    parameter logic RESET_LEVEL = 1'h1
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic level_o
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);
    logic meta_reg;
    logic sync_reg;
    logic [CW-1:0] count_reg;
    logic level_reg;
    wire differs = (sync_reg != level_reg);
    wire settled = (count_reg == CW'(STABLE_CYCLES - 1));

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            meta_reg <= RESET_LEVEL;
            sync_reg <= RESET_LEVEL;
            count_reg <= '0;
            level_reg <= RESET_LEVEL;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            // A glitch restarts the count, so only a held level is taken.
            if (!differs) begin
                count_reg <= '0;
            end else if (settled) begin
                count_reg <= '0;
                level_reg <= sync_reg;
            end else begin
                count_reg <= count_reg + CW'(1);
            end
        end
    end
    assign level_o = level_reg;
endmodule // input_debouncer

// ==== hdl/power_handshake.sv ====
/*
 * Module-side power sequencer: supply gating, carrier power-on, reset
 * hold to the carrier, boot gating and source, panel enables, standby.
 * Assumes carrier inputs are open-drain lines pulled up on the module and
 * asynchronous to sys_clk_i; reset_i is the system's own power-on reset.
 */
`timescale 1ns/1ps
`include "power_handshake_defines.svh"
module power_handshake #(
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter int RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
    parameter int PIXEL_WIDTH = 24,
    parameter logic ONLY_3V3_IO = 1'h0
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic input_power_bad_n_i,
    input wire logic io_voltage_sel_n_i,
    input wire logic carrier_reset_n_i,
    input wire logic boot_test_n_i,
    input wire logic sleep_request_n_i,
    input wire logic lid_closed_n_i,
    input wire logic battery_low_n_i,
    input wire logic charger_present_n_i,
    input wire logic supplies_ready_i,
    input wire logic standby_request_i,
    input wire logic panel_on_i,
    input wire logic backlight_on_i,
    input wire logic pixel_clock_i,
    input wire logic [PIXEL_WIDTH-1:0] pixel_data_i,
    output logic supply_enable_o,
    output logic carrier_power_on_o,
    output logic reset_out_n_o,
    output logic boot_release_o,
    output logic boot_source_o,
    output logic carrier_standby_n_o,
    output logic panel_supply_enable_o,
    output logic backlight_enable_o,
    output logic pixel_clock_out_o,
    output logic [PIXEL_WIDTH-1:0] pixel_data_o,
    output logic sleep_request_o,
    output logic lid_closed_o,
    output logic battery_low_o,
    output logic charger_present_o
);
    localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);
    localparam int NIN = 8;

    power_handshake_pkg::seq_state_e state_reg, state_next;
    logic [HW-1:0] hold_reg, hold_next;
    logic boot_source_reg;
    logic pix_clk_prev_reg;
    logic [PIXEL_WIDTH-1:0] pixel_data_reg;
    logic supply_en_reg, pwr_on_reg, rst_out_n_reg, boot_reg;
    logic stby_n_reg, panel_reg, bklt_reg;
    logic [3:0] status_reg;

    // Every carrier pin but the pixel clock and power-bad passes the same synchroniser and filter.
    wire [NIN-1:0] raw_pins = {pixel_clock_i, charger_present_n_i,
        battery_low_n_i, lid_closed_n_i, sleep_request_n_i, boot_test_n_i,
        carrier_reset_n_i, io_voltage_sel_n_i} ^ {1'h0, {NIN-1{1'h0}}};
    logic [NIN-1:0] clean;

    genvar gi;
    generate
        for (gi = 0; gi < NIN - 1; gi++) begin : g_deb
            input_debouncer #(
                .STABLE_CYCLES(DEBOUNCE_CYCLES),
                .RESET_LEVEL(1'h1)
            ) u_deb (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .async_i(raw_pins[gi]),
                .level_o(clean[gi])
            );
        end
    endgenerate

    // The pixel clock is only synchronised; a filter would eat its edges.
    input_debouncer #(
        .STABLE_CYCLES(1),
        .RESET_LEVEL(1'h0)
    ) u_pix_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(raw_pins[NIN-1]),
        .level_o(clean[NIN-1])
    );

    // Power-bad is only synchronised, not filtered, so it can cut supplies at once.
    logic pwr_bad_meta_reg, pwr_bad_sync_reg;

    wire io_sel_low = ~clean[0];
    wire carrier_rst_released = clean[1];
    wire card_boot = ~clean[2];
    wire pix_rise = clean[7] & ~pix_clk_prev_reg;
    wire power_bad = ~pwr_bad_sync_reg;
    wire io_refused = ONLY_3V3_IO & io_sel_low;
    wire power_blocked = power_bad | io_refused;
    wire hold_done = (hold_reg == HW'(RESET_HOLD_CYCLES - 1));
    wire sleeping = ~clean[3] | ~clean[4];
    wire go_standby = standby_request_i | sleeping;

    always_comb begin
        state_next = state_reg;
        hold_next = hold_reg;
        unique case (state_reg)
            power_handshake_pkg::ST_OFF: begin
                if (!power_blocked) begin
                    state_next = power_handshake_pkg::ST_SUPPLY_UP;
                end
            end
            power_handshake_pkg::ST_SUPPLY_UP: begin
                if (supplies_ready_i) begin
                    state_next = power_handshake_pkg::ST_CARRIER_UP;
                    hold_next = '0;
                end
            end
            power_handshake_pkg::ST_CARRIER_UP: begin
                hold_next = hold_reg + HW'(1);
                if (hold_done) begin
                    state_next = power_handshake_pkg::ST_WAIT_RESET;
                end
            end
            power_handshake_pkg::ST_WAIT_RESET: begin
                if (carrier_rst_released) begin
                    state_next = power_handshake_pkg::ST_BOOT;
                end
            end
            power_handshake_pkg::ST_BOOT: begin
                if (go_standby) begin
                    state_next = power_handshake_pkg::ST_STANDBY;
                end
            end
            power_handshake_pkg::ST_STANDBY: begin
                if (!go_standby) begin
                    state_next = power_handshake_pkg::ST_BOOT;
                end
            end
        endcase
        // Losing input power restarts from off at once; the carrier forcing reset in boot or standby returns to the reset wait.
        if (power_blocked) begin
            state_next = power_handshake_pkg::ST_OFF;
        end else if (!carrier_rst_released &&
                (state_reg == power_handshake_pkg::ST_BOOT ||
                 state_reg == power_handshake_pkg::ST_STANDBY)) begin
            state_next = power_handshake_pkg::ST_WAIT_RESET;
        end
    end

    wire st_wait = (state_reg == power_handshake_pkg::ST_WAIT_RESET);
    wire st_run = (state_reg == power_handshake_pkg::ST_BOOT);
    wire ns_off = (state_next == power_handshake_pkg::ST_OFF);
    wire ns_carrier = (state_next == power_handshake_pkg::ST_CARRIER_UP);
    wire ns_run = (state_next == power_handshake_pkg::ST_BOOT);
    wire ns_stby = (state_next == power_handshake_pkg::ST_STANDBY);
    wire ns_hold = ns_off || (state_next == power_handshake_pkg::ST_SUPPLY_UP)
        || ns_carrier;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pwr_bad_meta_reg <= 1'h0;
            pwr_bad_sync_reg <= 1'h0;
        end else begin
            pwr_bad_meta_reg <= input_power_bad_n_i;
            pwr_bad_sync_reg <= pwr_bad_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= power_handshake_pkg::ST_OFF;
            hold_reg <= '0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            supply_en_reg <= 1'h0;
            pwr_on_reg <= 1'h0;
            rst_out_n_reg <= 1'h0;
            boot_reg <= 1'h0;
            stby_n_reg <= 1'h1;
        end else begin
            supply_en_reg <= !ns_off;
            // Power-on rises as the supply wait ends, so the whole reset
            // hold to the carrier is counted after it.
            pwr_on_reg <= ns_carrier || !ns_hold;
            rst_out_n_reg <= !ns_hold;
            boot_reg <= ns_run | ns_stby;
            stby_n_reg <= !ns_stby;
        end
    end

    // The boot source is latched when the carrier releases reset.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            boot_source_reg <= `BOOT_FROM_NOR;
        end else if (st_wait && carrier_rst_released) begin
            boot_source_reg <= card_boot ? `BOOT_FROM_CARD
                                         : `BOOT_FROM_NOR;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            panel_reg <= 1'h0;
            bklt_reg <= 1'h0;
        end else begin
            panel_reg <= st_run & panel_on_i;
            bklt_reg <= st_run & panel_on_i & backlight_on_i;
        end
    end

    // Data is launched on the sampled rising edge of the pixel clock.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pix_clk_prev_reg <= 1'h0;
            pixel_data_reg <= '0;
        end else begin
            pix_clk_prev_reg <= clean[7];
            if (pix_rise) begin
                pixel_data_reg <= pixel_data_i;
            end
        end
    end

    // Status pins are active low; the outputs show the asserted condition.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            status_reg <= 4'h0;
        end else begin
            status_reg <= ~clean[6:3];
        end
    end

    assign supply_enable_o = supply_en_reg;
    assign carrier_power_on_o = pwr_on_reg;
    assign reset_out_n_o = rst_out_n_reg;
    assign boot_release_o = boot_reg;
    assign boot_source_o = boot_source_reg;
    assign carrier_standby_n_o = stby_n_reg;
    assign panel_supply_enable_o = panel_reg;
    assign backlight_enable_o = bklt_reg;
    assign pixel_clock_out_o = pix_clk_prev_reg;
    assign pixel_data_o = pixel_data_reg;
    assign sleep_request_o = status_reg[0];
    assign lid_closed_o = status_reg[1];
    assign battery_low_o = status_reg[2];
    assign charger_present_o = status_reg[3];
endmodule // power_handshake

// ==== verification/carrier_model.sv ====
/* Carrier side: power-bad line and reset line, both open drain.
   Assumes pull-ups on the module, so a released line reads high. */
`timescale 1ns/1ps
module carrier_model (
    input wire logic sys_clk_i,
    input wire logic carrier_power_on_i,
    input wire logic bad_i,
    input wire logic hold_reset_i,
    output logic power_bad_n_o,
    output logic carrier_reset_n_o
);
    logic [3:0] ramp_reg;
    // The ramp stands for the carrier rails, dark until power-on.
    always_ff @(posedge sys_clk_i) begin
        if (!carrier_power_on_i)
            ramp_reg <= 4'h0;
        else if (ramp_reg != 4'hF)
            ramp_reg <= ramp_reg + 4'h1;
    end
    assign power_bad_n_o = !bad_i;
    // Reset is let go last, as the power-good sign of the carrier.
    assign carrier_reset_n_o = (ramp_reg == 4'hF)
        && !hold_reset_i;
endmodule // carrier_model

// ==== verification/power_handshake_assertions.sv ====
/* Port checker for the power handshake.
   Assumes debounce and reset-hold counts of 4 cycles. */
`timescale 1ns/1ps
module power_handshake_assertions #(
    parameter int PIXEL_WIDTH = 24
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic input_power_bad_n_i,
    input wire logic carrier_reset_n_i,
    input wire logic boot_test_n_i,
    input wire logic battery_low_n_i,
    input wire logic supplies_ready_i,
    input wire logic standby_request_i,
    input wire logic supply_enable_o,
    input wire logic carrier_power_on_o,
    input wire logic reset_out_n_o,
    input wire logic boot_release_o,
    input wire logic boot_source_o,
    input wire logic carrier_standby_n_o,
    input wire logic panel_supply_enable_o,
    input wire logic backlight_enable_o,
    input wire logic pixel_clock_out_o,
    input wire logic [PIXEL_WIDTH-1:0] pixel_data_o,
    input wire logic battery_low_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    a_bad_supply_off: assert property (
        !input_power_bad_n_i [*5] |-> !supply_enable_o)
        else $error("supply on under power bad");
    a_power_on_cause: assert property (
        $rose(carrier_power_on_o) |->
        supply_enable_o && $past(supplies_ready_i))
        else $error("power-on without ready supplies");
    a_reset_out_hold: assert property (
        $rose(carrier_power_on_o) |-> !reset_out_n_o [*4])
        else $error("reset to carrier released too soon");
    a_boot_order: assert property (
        boot_release_o |-> carrier_power_on_o && reset_out_n_o)
        else $error("boot out of order");
    a_boot_after_release: assert property (
        $rose(boot_release_o) |->
        $past(carrier_reset_n_i, 3) && $past(carrier_reset_n_i, 6))
        else $error("boot while carrier reset held");
    a_boot_source_pick: assert property (
        $rose(boot_release_o) |-> boot_source_o == !boot_test_n_i)
        else $error("wrong boot source");
    a_standby_entry: assert property (
        boot_release_o && standby_request_i && input_power_bad_n_i &&
        carrier_reset_n_i |=> !carrier_standby_n_o)
        else $error("standby not shown");
    a_backlight_gate: assert property (
        backlight_enable_o |-> panel_supply_enable_o)
        else $error("backlight without panel");
    a_pixel_edge: assert property (
        !$stable(pixel_data_o) |-> $rose(pixel_clock_out_o))
        else $error("pixel data off the rising edge");
    a_battery_level: assert property (
        !battery_low_n_i [*8] |=> battery_low_o)
        else $error("battery low not shown");
endmodule // power_handshake_assertions

bind power_handshake power_handshake_assertions #(
    .PIXEL_WIDTH(PIXEL_WIDTH)) chk (.sys_clk_i, .reset_i, .input_power_bad_n_i,
    .carrier_reset_n_i, .boot_test_n_i, .battery_low_n_i, .supplies_ready_i,
    .standby_request_i, .supply_enable_o, .carrier_power_on_o, .reset_out_n_o,
    .boot_release_o, .boot_source_o, .carrier_standby_n_o, .pixel_data_o,
    .panel_supply_enable_o, .backlight_enable_o, .pixel_clock_out_o,
    .battery_low_o);

// ==== verification/power_handshake_test.sv ====
/* Bench: power-up, panel, standby, status inputs, carrier reset, power bad.
   Assumes the carrier model drives power-bad and the carrier reset line. */
`timescale 1ns/1ps
`include "power_handshake_defines.svh"
module power_handshake_test;
    localparam int DB = 4;
    logic sys_clk_i = 1'h0, reset_i = 1'h1, bad = 1'h0, hold = 1'h0;
    logic io_voltage_sel_n_i = 1'h1, boot_test_n_i = 1'h1;
    logic sleep_request_n_i = 1'h1, lid_closed_n_i = 1'h1;
    logic battery_low_n_i = 1'h1, charger_present_n_i = 1'h1;
    logic supplies_ready_i = 1'h0, standby_request_i = 1'h0;
    logic panel_on_i = 1'h0, backlight_on_i = 1'h0, pixel_clock_i = 1'h0;
    logic [23:0] pixel_data_i = 24'h0, pixel_data_o;
    logic input_power_bad_n_i, carrier_reset_n_i, supply_enable_o;
    logic carrier_power_on_o, reset_out_n_o, boot_release_o, boot_source_o;
    logic carrier_standby_n_o, panel_supply_enable_o, backlight_enable_o;
    logic pixel_clock_out_o, sleep_request_o, lid_closed_o, battery_low_o;
    logic charger_present_o;
    int n_fail = 0, check_count = 0;

    power_handshake #(.DEBOUNCE_CYCLES(DB), .RESET_HOLD_CYCLES(4),
        .ONLY_3V3_IO(1'h1)) dut (
        .sys_clk_i, .reset_i, .input_power_bad_n_i, .io_voltage_sel_n_i,
        .carrier_reset_n_i, .boot_test_n_i, .sleep_request_n_i,
        .lid_closed_n_i, .battery_low_n_i, .charger_present_n_i,
        .supplies_ready_i, .standby_request_i, .panel_on_i, .backlight_on_i,
        .pixel_clock_i, .pixel_data_i, .supply_enable_o, .carrier_power_on_o,
        .reset_out_n_o, .boot_release_o, .boot_source_o, .carrier_standby_n_o,
        .panel_supply_enable_o, .backlight_enable_o, .pixel_clock_out_o,
        .pixel_data_o, .sleep_request_o, .lid_closed_o, .battery_low_o,
        .charger_present_o);
    carrier_model carrier (.sys_clk_i, .carrier_power_on_i(carrier_power_on_o),
        .bad_i(bad), .hold_reset_i(hold), .power_bad_n_o(input_power_bad_n_i),
        .carrier_reset_n_o(carrier_reset_n_i));

    initial forever #5 sys_clk_i = !sys_clk_i;
    always @(negedge sys_clk_i) begin
        pixel_data_i <= pixel_data_i + 24'h1;
        if (pixel_data_i[2:0] == 3'h7)
            pixel_clock_i <= !pixel_clock_i;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // Bounded so a stuck sequencer ends the run instead of hanging it.
    task automatic wait_for(ref logic sig, input logic lvl);
        for (int i = 0; i < 200 && sig !== lvl; i++)
            @(negedge sys_clk_i);
        if (sig !== lvl) begin
            n_fail++;
            $display("Error wait expected %h seen %h", lvl, sig);
            print_verdict();
        end
    endtask

    task automatic t_powerup();
        wait_for(supply_enable_o, 1'h1);
        tick(4);
        check("power_on early", carrier_power_on_o, 1'h0);
        supplies_ready_i = 1'h1;
        wait_for(carrier_power_on_o, 1'h1);
        check("reset_out_n", reset_out_n_o, 1'h0);
        wait_for(reset_out_n_o, 1'h1);
        check("boot early", boot_release_o, 1'h0);
        wait_for(boot_release_o, 1'h1);
        check("source nor", boot_source_o, `BOOT_FROM_NOR);
    endtask
    task automatic t_pixel();
        logic [23:0] d;
        wait_for(pixel_clock_out_o, 1'h0);
        d = pixel_data_o;
        wait_for(pixel_clock_out_o, 1'h1);
        check("pixel new", pixel_data_o != d, 1'h1);
        d = pixel_data_o;
        tick(4);
        check("pixel clock", pixel_clock_out_o, 1'h1);
        check("pixel hold", pixel_data_o == d, 1'h1);
    endtask
    task automatic t_panel();
        backlight_on_i = 1'h1;
        tick(2);
        check("backlight alone", backlight_enable_o, 1'h0);
        panel_on_i = 1'h1;
        tick(2);
        check("panel", panel_supply_enable_o, 1'h1);
        check("backlight", backlight_enable_o, 1'h1);
        panel_on_i = 1'h0;
        tick(2);
        check("panel off", panel_supply_enable_o, 1'h0);
        backlight_on_i = 1'h0;
    endtask
    task automatic t_standby();
        standby_request_i = 1'h1;
        tick(2);
        check("standby", carrier_standby_n_o, 1'h0);
        standby_request_i = 1'h0;
        tick(2);
        check("awake", carrier_standby_n_o, 1'h1);
        sleep_request_n_i = 1'h0;
        tick(DB + 6);
        check("sleep", sleep_request_o, 1'h1);
        check("sleep standby", carrier_standby_n_o, 1'h0);
        sleep_request_n_i = 1'h1;
        lid_closed_n_i = 1'h0;
        tick(DB + 6);
        check("lid", lid_closed_o, 1'h1);
        check("lid standby", carrier_standby_n_o, 1'h0);
        lid_closed_n_i = 1'h1;
        tick(DB + 6);
        check("wake", carrier_standby_n_o, 1'h1);
    endtask
    task automatic t_status();
        battery_low_n_i = 1'h0;
        tick(DB - 1);
        battery_low_n_i = 1'h1;
        tick(DB + 6);
        check("battery glitch", battery_low_o, 1'h0);
        battery_low_n_i = 1'h0;
        charger_present_n_i = 1'h0;
        tick(DB + 6);
        check("battery low", battery_low_o, 1'h1);
        check("charger", charger_present_o, 1'h1);
        battery_low_n_i = 1'h1;
        tick(DB + 6);
        check("battery normal", battery_low_o, 1'h0);
    endtask
    task automatic t_reset_in();
        hold = 1'h1;
        wait_for(boot_release_o, 1'h0);
        boot_test_n_i = 1'h0;
        tick(2 * DB + 4);
        check("boot held", boot_release_o, 1'h0);
        hold = 1'h0;
        wait_for(boot_release_o, 1'h1);
        check("source card", boot_source_o, `BOOT_FROM_CARD);
    endtask
    task automatic t_power_bad();
        bad = 1'h1;
        tick(6);
        check("bad supply", supply_enable_o, 1'h0);
        check("bad power_on", carrier_power_on_o, 1'h0);
        bad = 1'h0;
        wait_for(boot_release_o, 1'h1);
    endtask
    // The block is built as the 3.3V-only variant, so a grounded strap
    // must cut its supplies.
    task automatic t_io_refuse();
        io_voltage_sel_n_i = 1'h0;
        tick(DB + 6);
        check("io refuse supply", supply_enable_o, 1'h0);
        check("io refuse power_on", carrier_power_on_o, 1'h0);
        io_voltage_sel_n_i = 1'h1;
        wait_for(boot_release_o, 1'h1);
    endtask

    initial begin
        tick(3);
        check("reset supply", supply_enable_o, 1'h0);
        check("reset standby_n", carrier_standby_n_o, 1'h1);
        reset_i = 1'h0;
        t_powerup();
        t_pixel();
        t_panel();
        t_standby();
        t_status();
        t_reset_in();
        t_power_bad();
        t_io_refuse();
        print_verdict();
    end
endmodule // power_handshake_test
